// ==== common/tcsr_pkg.sv ====
// Shared constants and types for the tone code serial readout block
package tcsr_pkg;
    localparam int unsigned CODE_BITS     = 4;
    localparam int unsigned TONE_COUNT    = 16;
    localparam int unsigned REF_CLOCK_HZ  = 4194304;
    localparam int unsigned SYS_CLOCK_HZ  = 50000000;
    localparam int unsigned SYS_PERIOD_NS = 20;
    localparam int unsigned PULSES_PER_READ = 4;
    localparam logic [3:0]  CODE_RESET    = 4'h0;
    localparam logic [2:0]  COUNT_RESET   = 3'h0;

    // Detected tone as seen from the front end
    typedef struct packed {
        logic       valid;
        logic [3:0] code;
    } tcsr_tone_t;

    // Readout state
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READY = 2'b01,
        ST_SHIFT = 2'b10,
        ST_DONE  = 2'b11
    } tcsr_state_t;
endpackage : tcsr_pkg

// ==== hw/tcsr_sync.sv ====
// Two-stage synchroniser with rising-edge detect on the stable stage
`timescale 1ns/1ps
`default_nettype none
module tcsr_sync (
    input  wire logic sys_clk,    // System clock
    input  wire logic rst,        // Async reset, active high
    input  wire logic asyncIn,    // Pin from outside the domain
    output logic      syncLevel,  // Synchronised level
    output logic      riseEdge    // One-cycle pulse on rising edge
);
    logic stage1;
    logic stage2;
    logic stage3;

    // First stage read only by second stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= asyncIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign syncLevel = stage2;
    assign riseEdge  = stage2 & ~stage3;
endmodule : tcsr_sync
`default_nettype wire

// ==== hw/tcsr_readout.sv ====
// Tone code serial readout: steering flag, serial shift-out, power-down
`timescale 1ns/1ps
`default_nettype none
module tcsr_readout #(
    parameter int unsigned CODE_W = tcsr_pkg::CODE_BITS  // Code width
) (
    input  wire logic             sys_clk,          // Reference clock
    input  wire logic             rst,              // Async reset, active high
    input  wire tcsr_pkg::tcsr_tone_t toneIn,       // Detector result, same domain
    input  wire logic             shiftPulse,       // Host acknowledge pulse pin
    input  wire logic             power_down_request, // Host power-down pin
    output logic                  valid_tone_flag,  // Steering output
    output logic                  serial_code_out,  // Serial code bit
    output logic                  powerDown         // Low-consumption mode active
);
    logic ackLevel;
    logic ackRise;
    logic pdLevel;
    logic pdRise;

    // Host pins cross into the reference clock domain
    tcsr_sync u_ackSync (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .asyncIn   (shiftPulse),
        .syncLevel (ackLevel),
        .riseEdge  (ackRise)
    );
    tcsr_sync u_pdSync (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .asyncIn   (power_down_request),
        .syncLevel (pdLevel),
        .riseEdge  (pdRise)
    );

    tcsr_pkg::tcsr_state_t state;
    tcsr_pkg::tcsr_state_t next_state;
    logic [CODE_W-1:0]     shiftReg;
    logic [CODE_W-1:0]     next_shiftReg;
    logic [2:0]            pulseCount;
    logic [2:0]            next_pulseCount;
    logic                  sdOut;
    logic                  next_sdOut;
    logic                  pdMode;
    logic                  next_pdMode;
    logic                  flagPrev;
    logic                  next_flagPrev;
    logic                  flagRise;

    // Shared shift step so capture and advance agree on direction
    function automatic logic [CODE_W-1:0] shiftDown(input logic [CODE_W-1:0] value);
        return value >> 1;
    endfunction : shiftDown

    // Flag follows the detector unless powered down
    assign valid_tone_flag = toneIn.valid & ~pdMode;
    assign flagRise        = valid_tone_flag & ~flagPrev;
    assign serial_code_out = sdOut;
    assign powerDown       = pdMode;

    // Next-state logic for readout and power-down
    always_comb begin
        next_state      = state;
        next_shiftReg   = shiftReg;
        next_pulseCount = pulseCount;
        next_sdOut      = sdOut;
        next_pdMode     = pdMode;
        next_flagPrev   = valid_tone_flag;
        // Entry only on a request rise with ack low; leaving needs request low
        if (!pdMode && pdRise && !ackLevel) begin
            next_pdMode = 1'b1;
        end else if (pdMode && !pdLevel) begin
            next_pdMode = 1'b0;
        end
        if (pdMode) begin
            // Re-arm so a held tone can be read again on return
            next_state      = tcsr_pkg::ST_IDLE;
            next_pulseCount = tcsr_pkg::COUNT_RESET;
        end else begin
            unique case (state)
                tcsr_pkg::ST_IDLE: begin
                    if (valid_tone_flag) begin
                        next_state = tcsr_pkg::ST_READY;
                    end
                end
                tcsr_pkg::ST_READY: begin
                    if (!valid_tone_flag) begin
                        next_state = tcsr_pkg::ST_IDLE;
                    end else if (ackRise) begin
                        // Capture code and present LSB together
                        next_shiftReg   = shiftDown(CODE_W'(toneIn.code));
                        next_sdOut      = toneIn.code[0];
                        next_pulseCount = 3'h1;
                        next_state      = tcsr_pkg::ST_SHIFT;
                    end
                end
                tcsr_pkg::ST_SHIFT: begin
                    if (ackRise) begin
                        next_sdOut      = shiftReg[0];
                        next_shiftReg   = shiftDown(shiftReg);
                        next_pulseCount = pulseCount + 3'h1;
                        if (pulseCount == 3'(tcsr_pkg::PULSES_PER_READ - 1)) begin
                            next_state = tcsr_pkg::ST_DONE;
                        end
                    end
                end
                tcsr_pkg::ST_DONE: begin
                    // Extra pulses ignored until flag rises anew
                    if (flagRise) begin
                        next_state = tcsr_pkg::ST_READY;
                    end else if (!valid_tone_flag) begin
                        next_state = tcsr_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Registers only; clock is the reference clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state      <= tcsr_pkg::ST_IDLE;
            shiftReg   <= tcsr_pkg::CODE_RESET;
            pulseCount <= tcsr_pkg::COUNT_RESET;
            sdOut      <= 1'b0;
            pdMode     <= 1'b0;
            flagPrev   <= 1'b0;
        end else begin
            state      <= next_state;
            shiftReg   <= next_shiftReg;
            pulseCount <= next_pulseCount;
            sdOut      <= next_sdOut;
            pdMode     <= next_pdMode;
            flagPrev   <= next_flagPrev;
        end
    end

    // First pulse puts the LSB out one cycle after the sync edge
    sequence s_firstPulse;
        state == tcsr_pkg::ST_READY && valid_tone_flag && ackRise && !pdMode;
    endsequence
    property p_lsbFirst;
        @(posedge sys_clk) disable iff (rst)
        s_firstPulse |=> (sdOut == $past(toneIn.code[0]));
    endproperty
    a_lsb_first: assert property (p_lsbFirst)
        else $error("LSB not presented on first pulse");

    a_flag_follows: assert property (@(posedge sys_clk) disable iff (rst)
        valid_tone_flag == (toneIn.valid && !pdMode))
        else $error("Flag does not follow tone");

    a_pd_entry: assert property (@(posedge sys_clk) disable iff (rst)
        (!pdMode && pdRise && !ackLevel) |=> pdMode)
        else $error("Power-down not entered");

    a_pd_blocked: assert property (@(posedge sys_clk) disable iff (rst)
        (!pdMode && pdRise && ackLevel) |=> !pdMode)
        else $error("Power-down entered with ack high");

    a_pd_exit: assert property (@(posedge sys_clk) disable iff (rst)
        (pdMode && !pdLevel) |=> !pdMode)
        else $error("Power-down not left");

    a_pd_rearm: assert property (@(posedge sys_clk) disable iff (rst)
        pdMode |=> state == tcsr_pkg::ST_IDLE)
        else $error("Readout not rearmed in power-down");

    a_count_bound: assert property (@(posedge sys_clk) disable iff (rst)
        pulseCount <= 3'(tcsr_pkg::PULSES_PER_READ))
        else $error("Pulse count beyond four");

    a_extra_ignored: assert property (@(posedge sys_clk) disable iff (rst)
        (state == tcsr_pkg::ST_DONE && ackRise) |=> $stable(sdOut))
        else $error("Extra pulse changed output");

    a_shift_next: assert property (@(posedge sys_clk) disable iff (rst)
        (state == tcsr_pkg::ST_SHIFT && ackRise && !pdMode)
            |=> sdOut == $past(shiftReg[0]))
        else $error("Shift did not advance bit");

    a_capture_code: assert property (@(posedge sys_clk) disable iff (rst)
        s_firstPulse |=> (shiftReg == ($past(toneIn.code) >> 1)))
        else $error("Code not captured");

    // Fourth taken pulse closes the read; later pulses must find DONE
    sequence s_fourthPulse;
        state == tcsr_pkg::ST_SHIFT && ackRise && !pdMode
            && pulseCount == 3'(tcsr_pkg::PULSES_PER_READ - 1);
    endsequence
    property p_readCloses;
        @(posedge sys_clk) disable iff (rst)
        s_fourthPulse |=> state == tcsr_pkg::ST_DONE;
    endproperty
    a_read_closes: assert property (p_readCloses)
        else $error("Read not closed after fourth pulse");

    // Serial bit moves only on a taken pulse, never between pulses
    a_bit_per_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        !ackRise |=> $stable(sdOut))
        else $error("Serial bit changed without a pulse");

    // Pulses while powered down must not wake the block
    a_pd_holds: assert property (@(posedge sys_clk) disable iff (rst)
        (pdMode && pdLevel) |=> pdMode)
        else $error("Power-down left while request held");
endmodule : tcsr_readout
`default_nettype wire

// ==== testbench/tcsr_host.sv ====
// Host model that clocks tone codes out and drives the power-down request
`timescale 1ns/1ps
`default_nettype none
module tcsr_host (
    input  wire logic sys_clk,            // System clock, paces the host
    input  wire logic serial_code_out,    // Serial code bit from the block
    output logic      shiftPulse,         // Acknowledge pulse pin
    output logic      power_down_request  // Power-down request pin
);
    // Both pins idle low from time zero
    initial begin
        shiftPulse = 1'b0;
        power_down_request = 1'b0;
    end

    // One 80 ns pulse, then 80 ns low; bit sampled late in the low half, well past the answer
    task automatic pulse(output logic bitSeen);
        @(posedge sys_clk);
        shiftPulse <= 1'b1;
        repeat (4) @(posedge sys_clk);
        shiftPulse <= 1'b0;
        repeat (4) @(posedge sys_clk);
        bitSeen = serial_code_out;
    endtask : pulse

    // Always a full set of four, LSB first; fewer would spoil the next tone
    task automatic readCode(output logic [3:0] code);
        for (int b = 0; b < 4; b++) begin
            pulse(code[b]);
        end
    endtask : readCode

    // Sets both pins together, then lets the synchronisers settle
    task automatic setPins(input logic ack, input logic req);
        @(posedge sys_clk);
        shiftPulse <= ack;
        power_down_request <= req;
        repeat (6) @(posedge sys_clk);
    endtask : setPins
endmodule : tcsr_host
`default_nettype wire

// ==== testbench/test_tcsr_readout.sv ====
// Self-checking bench for the tone code serial readout
`timescale 1ns/1ps
`default_nettype none
module test_tcsr_readout;
    logic                 sys_clk;    // System clock
    logic                 rst;        // Reset
    tcsr_pkg::tcsr_tone_t toneIn;     // Detector result
    logic                 shiftPulse; // Ack pin
    logic                 pdReq;      // Power-down request pin
    logic                 flag;       // Steering output
    logic                 sd;         // Serial code bit
    logic                 powerDown;  // Power-down state
    int                   nFail;      // Mismatches
    int                   nCompared;  // Comparisons
    int                   cycles;     // Watchdog count
    logic [3:0]           code;       // Code read back

    tcsr_readout u_tcsr_readout (.sys_clk(sys_clk), .rst(rst), .toneIn(toneIn),
        .shiftPulse(shiftPulse), .power_down_request(pdReq), .valid_tone_flag(flag),
        .serial_code_out(sd), .powerDown(powerDown));
    tcsr_host u_tcsr_host (.sys_clk(sys_clk), .serial_code_out(sd),
        .shiftPulse(shiftPulse), .power_down_request(pdReq));

    // Clock of 20 ns
    always #10 sys_clk = ~sys_clk;

    task automatic check(input logic [3:0] seen, input logic [3:0] expected);
        nCompared++;
        if (seen !== expected) begin
            nFail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask : check

    task automatic testDone;
        $display("compared %0d, mismatches %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : testDone

    // Watchdog: whole run needs about 1000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 10000) begin
            nFail++;
            testDone();
        end
    end

    // Every code once; a stale code before the first pulse must not be taken
    task automatic testCodes;
        logic b;
        for (int i = 0; i < 16; i++) begin
            toneIn <= {1'b1, ~4'(i)};
            repeat (3) @(posedge sys_clk);
            check(4'(flag), 4'h1);
            toneIn <= {1'b1, 4'(i)};
            repeat (2) @(posedge sys_clk);
            u_tcsr_host.readCode(code);
            check(code, 4'(i));
            u_tcsr_host.pulse(b);
            check(4'(b), 4'(i >> 3));
            toneIn <= {1'b0, 4'(i)};
            repeat (3) @(posedge sys_clk);
            check(4'(flag), 4'h0);
        end
    endtask : testCodes

    // Power-down entry, a pulse meanwhile, exit and a second read
    task automatic testPowerDown;
        logic b;
        toneIn <= {1'b1, 4'h9};
        repeat (3) @(posedge sys_clk);
        u_tcsr_host.readCode(code);
        check(code, 4'h9);
        u_tcsr_host.setPins(1'b0, 1'b1);
        check({2'b00, powerDown, flag}, 4'h2);
        u_tcsr_host.pulse(b);
        check({2'b00, powerDown, flag}, 4'h2);
        u_tcsr_host.setPins(1'b0, 1'b0);
        check({2'b00, powerDown, flag}, 4'h1);
        u_tcsr_host.readCode(code);
        check(code, 4'h9);
        // Request raised with ack high is not an entry
        u_tcsr_host.setPins(1'b1, 1'b0);
        u_tcsr_host.setPins(1'b1, 1'b1);
        check(4'(powerDown), 4'h0);
        u_tcsr_host.setPins(1'b0, 1'b0);
    endtask : testPowerDown

    // Reset for 20 cycles, then the scenarios
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        toneIn = '0;
        nFail = 0;
        nCompared = 0;
        cycles = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        testCodes();
        testPowerDown();
        testDone();
    end
endmodule : test_tcsr_readout
`default_nettype wire
